// [design/qsq_top.sv]
// Functional notes
// - input-port mode stores the sample when the qualifier is high at the edge.
// - input-port mode drops the sample when low; write position stays put.
// - without an internal node selected, the qualifier comes from a dedicated pin.
// - transitional mode stores when any inspected signal changed since last cycle.
// - transitional mode stores nothing when no inspected signal changed.
// - conditional mode stores only in cycles where the configured function is true.
// - each signal matches don't care, low, high, fall, rise or either edge.
// - all-terms combination is true only when every term matches.
// - advanced condition compares masked probes relationally against a value each cycle.
// - with discontinuity recording, flag stored samples that follow paused cycles.
// - continuous type, or disabled qualifier, writes every cycle.
// - trigger is checked every running cycle, regardless of write enable.
// - output is a per-cycle write enable, active from acquisition start.
//
// Design decisions made here: the APB slave port and the address map.
module qsq_top
    import qsq_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          ce,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    input  wire logic [PW-1:0] probe,
    input  wire logic          qual_pin,
    input  wire logic          qual_node,
    output qsq_wr_t            wr,
    output logic               triggered
);

    // register state
    qsq_ctrl_t        ctrl_reg,     ctrl_next;
    logic [PW-1:0]    tmask_reg,    tmask_next;
    logic [PW*CW-1:0] cond_reg,     cond_next;
    logic [PW-1:0]    amask_reg,    amask_next;
    logic [PW-1:0]    aval_reg,     aval_next;
    logic [PW-1:0]    gmask_reg,    gmask_next;
    logic [PW-1:0]    gval_reg,     gval_next;
    logic             start_reg,    start_next;
    logic             stop_reg,     stop_next;
    logic             ld_reg,       ld_next;
    logic [31:0]      rdata_reg,    rdata_next;

    // acquisition state
    qsq_state_t       state_reg,    state_next;
    logic [PW-1:0]    prev_reg,     prev_next;
    logic             pause_reg,    pause_next;
    logic [AW-1:0]    ptr_reg,      ptr_next;
    logic [15:0]      count_reg,    count_next;
    qsq_wr_t          wr_reg,       wr_next;

    logic             addr_ok;
    logic             done;
    logic             wr_acc;
    logic [7:0]       ofs;
    logic [31:0]      rd_mux;
    logic [31:0]      ctrl_word;
    logic [PW-1:0]    hit;
    logic [PW-1:0]    care;
    logic             qual_in;
    logic             trans_hit;
    logic             basic_and;
    logic             basic_or;
    logic             adv_hit;
    logic             cond_hit;
    logic             store;
    logic             trig_hit;
    logic [PW-1:0]    adv_probe;

    assign ofs = paddr[7:0];

    // decode; anything past the map or with upper address bits set is refused
    always_comb begin
        case (ofs)
            OFS_CTRL, OFS_TMASK, OFS_COND0, OFS_COND1, OFS_ADV_MASK,
            OFS_ADV_VAL, OFS_TRG_MASK, OFS_TRG_VAL, OFS_STATUS,
            OFS_COUNT: addr_ok = (paddr[31:8] == 24'h00_0000);
            default:   addr_ok = 1'b0;
        endcase
    end

    // ready only while the clock enable lets the edge count
    assign pready  = ld_reg & penable & psel & ce;
    assign pslverr = pready & ~addr_ok;
    assign done    = pready;
    assign wr_acc  = done & pwrite & addr_ok;
    assign prdata  = rdata_reg;

    always_comb begin
        ctrl_word = RST_WORD;
        ctrl_word[CTRL_MODE_LSB +: 2] = ctrl_reg.mode;
        ctrl_word[CTRL_COMB_LSB +: 2] = ctrl_reg.comb;
        ctrl_word[CTRL_DISC_BIT]      = ctrl_reg.disc_en;
        ctrl_word[CTRL_QSRC_BIT]      = ctrl_reg.qsrc_int;
        ctrl_word[CTRL_DISQ_BIT]      = ctrl_reg.disq;
        ctrl_word[CTRL_OP_LSB +: 3]   = ctrl_reg.op;
    end

    // read mux; start and stop bits always read as zero
    always_comb begin
        rd_mux = RST_WORD;
        case (ofs)
            OFS_CTRL:     rd_mux = ctrl_word;
            OFS_TMASK:    rd_mux[PW-1:0] = tmask_reg;
            OFS_COND0:    rd_mux = cond_reg[31:0];
            OFS_COND1:    rd_mux = cond_reg[63:32];
            OFS_ADV_MASK: rd_mux[PW-1:0] = amask_reg;
            OFS_ADV_VAL:  rd_mux[PW-1:0] = aval_reg;
            OFS_TRG_MASK: rd_mux[PW-1:0] = gmask_reg;
            OFS_TRG_VAL:  rd_mux[PW-1:0] = gval_reg;
            OFS_STATUS: begin
                rd_mux[STAT_RUN_BIT]       = (state_reg == QSQ_ST_RUN);
                rd_mux[STAT_TRG_BIT]       = (state_reg == QSQ_ST_TRIG);
                rd_mux[STAT_PTR_LSB +: AW] = ptr_reg;
            end
            OFS_COUNT:    rd_mux[15:0] = count_reg;
            default:      rd_mux = RST_WORD;
        endcase
    end

    // register file next values; read data is latched in the setup cycle
    always_comb begin
        ctrl_next  = ctrl_reg;
        tmask_next = tmask_reg;
        cond_next  = cond_reg;
        amask_next = amask_reg;
        aval_next  = aval_reg;
        gmask_next = gmask_reg;
        gval_next  = gval_reg;
        start_next = 1'b0;
        stop_next  = 1'b0;
        ld_next    = ld_reg;
        rdata_next = rdata_reg;
        if (done) begin
            ld_next = 1'b0;
        end else if (psel) begin
            ld_next    = 1'b1;
            rdata_next = rd_mux;
        end
        if (wr_acc) begin
            case (ofs)
                OFS_CTRL: begin
                    ctrl_next.mode     = qsq_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
                    ctrl_next.comb     = qsq_comb_t'(pwdata[CTRL_COMB_LSB +: 2]);
                    ctrl_next.disc_en  = pwdata[CTRL_DISC_BIT];
                    ctrl_next.qsrc_int = pwdata[CTRL_QSRC_BIT];
                    ctrl_next.disq     = pwdata[CTRL_DISQ_BIT];
                    ctrl_next.op       = qsq_op_t'(pwdata[CTRL_OP_LSB +: 3]);
                    start_next         = pwdata[CTRL_STRT_BIT];
                    stop_next          = pwdata[CTRL_STOP_BIT];
                end
                OFS_TMASK:    tmask_next = pwdata[PW-1:0];
                OFS_COND0:    cond_next[31:0] = pwdata;
                OFS_COND1:    cond_next[63:32] = pwdata;
                OFS_ADV_MASK: amask_next = pwdata[PW-1:0];
                OFS_ADV_VAL:  aval_next = pwdata[PW-1:0];
                OFS_TRG_MASK: gmask_next = pwdata[PW-1:0];
                OFS_TRG_VAL:  gval_next = pwdata[PW-1:0];
                default:      ctrl_next = ctrl_reg;   // status and count are read-only
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg  <= RST_CTRL;
            tmask_reg <= RST_MASK;
            cond_reg  <= RST_COND;
            amask_reg <= RST_MASK;
            aval_reg  <= RST_MASK;
            gmask_reg <= RST_MASK;
            gval_reg  <= RST_MASK;
            start_reg <= 1'b0;
            stop_reg  <= 1'b0;
            ld_reg    <= 1'b0;
            rdata_reg <= RST_WORD;
        end else if (ce) begin
            ctrl_reg  <= ctrl_next;
            tmask_reg <= tmask_next;
            cond_reg  <= cond_next;
            amask_reg <= amask_next;
            aval_reg  <= aval_next;
            gmask_reg <= gmask_next;
            gval_reg  <= gval_next;
            start_reg <= start_next;
            stop_reg  <= stop_next;
            ld_reg    <= ld_next;
            rdata_reg <= rdata_next;
        end
    end

    // one match term per probe bit
    genvar gi;
    generate
        for (gi = 0; gi < PW; gi++) begin : g_term
            qsq_match u_match (
                .code (cond_reg[gi*CW +: CW]),
                .cur  (probe[gi]),
                .prev (prev_reg[gi]),
                .hit  (hit[gi]),
                .care (care[gi])
            );
        end
    endgenerate

    // qualifier source: the pin unless an internal node is chosen
    assign qual_in   = ctrl_reg.qsrc_int ? qual_node : qual_pin;
    assign trans_hit = |((probe ^ prev_reg) & tmask_reg);
    assign basic_and = &hit;
    assign basic_or  = |(hit & care);
    assign adv_probe = probe & amask_reg;

    // relational compare covers equality, inequality and thresholds against the one value
    always_comb begin
        case (ctrl_reg.op)
            QSQ_OP_EQ: adv_hit = (adv_probe == aval_reg);
            QSQ_OP_NE: adv_hit = (adv_probe != aval_reg);
            QSQ_OP_LT: adv_hit = (adv_probe <  aval_reg);
            QSQ_OP_GT: adv_hit = (adv_probe >  aval_reg);
            QSQ_OP_LE: adv_hit = (adv_probe <= aval_reg);
            QSQ_OP_GE: adv_hit = (adv_probe >= aval_reg);
            default:   adv_hit = 1'b0;
        endcase
    end

    always_comb begin
        case (ctrl_reg.comb)
            QSQ_COMB_AND: cond_hit = basic_and;
            QSQ_COMB_OR:  cond_hit = basic_or;
            QSQ_COMB_ADV: cond_hit = adv_hit;
            default:      cond_hit = 1'b0;
        endcase
    end

    // per-cycle store decision
    always_comb begin
        if (ctrl_reg.disq) begin
            store = 1'b1;
        end else begin
            case (ctrl_reg.mode)
                QSQ_MODE_CONT:  store = 1'b1;
                QSQ_MODE_PORT:  store = qual_in;
                QSQ_MODE_TRANS: store = trans_hit;
                QSQ_MODE_COND:  store = cond_hit;
                default:        store = 1'b0;
            endcase
        end
    end

    // zero trigger mask means no trigger, so capture runs until stopped
    assign trig_hit = (gmask_reg != RST_MASK) & ((probe & gmask_reg) == gval_reg);

    // acquisition next values; the trigger cycle's own sample is still qualified
    always_comb begin
        state_next = state_reg;
        prev_next  = probe;
        pause_next = pause_reg;
        ptr_next   = ptr_reg;
        count_next = count_reg;
        wr_next    = wr_reg;
        wr_next.en = 1'b0;
        case (state_reg)
            QSQ_ST_IDLE, QSQ_ST_TRIG: begin
                if (start_reg) begin
                    state_next = QSQ_ST_RUN;
                    pause_next = 1'b0;
                    ptr_next   = '0;
                    count_next = '0;
                end
            end
            QSQ_ST_RUN: begin
                if (store) begin
                    wr_next.en   = 1'b1;
                    wr_next.data = probe;
                    wr_next.addr = ptr_reg;
                    wr_next.disc = ctrl_reg.disc_en & pause_reg;
                    ptr_next     = ptr_reg + 1'b1;
                    count_next   = count_reg + 1'b1;
                    pause_next   = 1'b0;
                end else begin
                    pause_next   = 1'b1;
                end
                if (stop_reg) begin
                    state_next = QSQ_ST_IDLE;
                end else if (trig_hit) begin
                    state_next = QSQ_ST_TRIG;
                end
            end
            default: state_next = QSQ_ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= QSQ_ST_IDLE;
            prev_reg  <= RST_MASK;
            pause_reg <= 1'b0;
            ptr_reg   <= '0;
            count_reg <= '0;
            wr_reg    <= '0;
        end else if (ce) begin
            state_reg <= state_next;
            prev_reg  <= prev_next;
            pause_reg <= pause_next;
            ptr_reg   <= ptr_next;
            count_reg <= count_next;
            wr_reg    <= wr_next;
        end
    end

    assign wr        = wr_reg;
    assign triggered = (state_reg == QSQ_ST_TRIG);

endmodule // qsq_top

// [pkg/qsq_pkg.sv]
package qsq_pkg;

    // probe width and write-position width
    localparam int unsigned PW = 16;
    localparam int unsigned AW = 8;
    localparam int unsigned CW = 4;   // bits per match code

    // register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_TMASK     = 8'h04;
    localparam logic [7:0] OFS_COND0     = 8'h08;
    localparam logic [7:0] OFS_COND1     = 8'h0C;
    localparam logic [7:0] OFS_ADV_MASK  = 8'h10;
    localparam logic [7:0] OFS_ADV_VAL   = 8'h14;
    localparam logic [7:0] OFS_TRG_MASK  = 8'h18;
    localparam logic [7:0] OFS_TRG_VAL   = 8'h1C;
    localparam logic [7:0] OFS_STATUS    = 8'h20;
    localparam logic [7:0] OFS_COUNT     = 8'h24;

    // control register field positions
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_COMB_LSB = 2;
    localparam int unsigned CTRL_DISC_BIT = 4;
    localparam int unsigned CTRL_QSRC_BIT = 5;
    localparam int unsigned CTRL_DISQ_BIT = 6;
    localparam int unsigned CTRL_STRT_BIT = 8;
    localparam int unsigned CTRL_STOP_BIT = 9;
    localparam int unsigned CTRL_OP_LSB   = 12;

    // status register field positions
    localparam int unsigned STAT_RUN_BIT  = 0;
    localparam int unsigned STAT_TRG_BIT  = 1;
    localparam int unsigned STAT_PTR_LSB  = 8;

    // reset values
    localparam logic [PW-1:0]    RST_MASK = 16'h0000;
    localparam logic [PW*CW-1:0] RST_COND = 64'h0000_0000_0000_0000;
    localparam logic [31:0]      RST_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        QSQ_MODE_CONT  = 2'b00,
        QSQ_MODE_PORT  = 2'b01,
        QSQ_MODE_TRANS = 2'b10,
        QSQ_MODE_COND  = 2'b11
    } qsq_mode_t;

    typedef enum logic [1:0] {
        QSQ_COMB_AND = 2'b00,
        QSQ_COMB_OR  = 2'b01,
        QSQ_COMB_ADV = 2'b10,
        QSQ_COMB_RSV = 2'b11
    } qsq_comb_t;

    // per-signal match codes
    localparam logic [CW-1:0] MT_DC   = 4'h0;
    localparam logic [CW-1:0] MT_LOW  = 4'h1;
    localparam logic [CW-1:0] MT_HIGH = 4'h2;
    localparam logic [CW-1:0] MT_FALL = 4'h3;
    localparam logic [CW-1:0] MT_RISE = 4'h4;
    localparam logic [CW-1:0] MT_EDGE = 4'h5;

    typedef enum logic [2:0] {
        QSQ_OP_EQ = 3'b000,
        QSQ_OP_NE = 3'b001,
        QSQ_OP_LT = 3'b010,
        QSQ_OP_GT = 3'b011,
        QSQ_OP_LE = 3'b100,
        QSQ_OP_GE = 3'b101
    } qsq_op_t;

    typedef enum logic [1:0] {
        QSQ_ST_IDLE = 2'b00,
        QSQ_ST_RUN  = 2'b01,
        QSQ_ST_TRIG = 2'b10
    } qsq_state_t;

    typedef struct packed {
        qsq_op_t   op;
        logic      disq;
        logic      qsrc_int;
        logic      disc_en;
        qsq_comb_t comb;
        qsq_mode_t mode;
    } qsq_ctrl_t;

    localparam qsq_ctrl_t RST_CTRL = '{op: QSQ_OP_EQ, disq: 1'b0, qsrc_int: 1'b0,
                                       disc_en: 1'b0, comb: QSQ_COMB_AND,
                                       mode: QSQ_MODE_CONT};

    typedef struct packed {
        logic          en;
        logic          disc;
        logic [AW-1:0] addr;
        logic [PW-1:0] data;
    } qsq_wr_t;

endpackage

// [design/qsq_match.sv]
module qsq_match
    import qsq_pkg::*;
(
    input  wire logic [CW-1:0] code,
    input  wire logic          cur,
    input  wire logic          prev,
    output logic               hit,
    output logic               care
);

    // one term; edges judged against the previous cycle
    always_comb begin
        care = (code != MT_DC);
        case (code)
            MT_DC:   hit = 1'b1;
            MT_LOW:  hit = ~cur;
            MT_HIGH: hit = cur;
            MT_FALL: hit = prev & ~cur;
            MT_RISE: hit = ~prev & cur;
            MT_EDGE: hit = prev ^ cur;
            default: hit = 1'b0;   // unused codes never match
        endcase
    end

endmodule // qsq_match

// [verification/qsq_top_monitor.sv]
module qsq_top_monitor
    import qsq_pkg::*;
(
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          ce,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [31:0]   paddr,
    input wire logic [31:0]   pwdata,
    input wire logic          pready,
    input wire logic [31:0]   prdata,
    input wire logic          pslverr,
    input wire logic [PW-1:0] probe,
    input wire logic          qual_pin,
    input wire logic          qual_node,
    input wire qsq_wr_t       wr,
    input wire logic          triggered
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [6:0]    cfg_reg, cfg_next;
    logic [PW-1:0] tm_reg, tm_next, prv_reg;
    logic [1:0]    qt_reg, qt_next;
    logic          wdone, quiet, q_on;

    // shadow of control and inspect mask; the mode checks wait 3 edges after a control write
    assign wdone = psel & penable & pready & pwrite;
    assign quiet = (qt_reg == 2'd3) && !wdone;
    assign q_on  = quiet && !cfg_reg[CTRL_DISQ_BIT];
    always_comb begin
        cfg_next = cfg_reg;
        tm_next = tm_reg;
        qt_next = (qt_reg == 2'd3) ? qt_reg : qt_reg + 2'd1;
        if (wdone && paddr == 32'(OFS_CTRL)) begin
            cfg_next = pwdata[6:0];
            qt_next = 2'd0;
        end
        if (wdone && paddr == 32'(OFS_TMASK)) begin
            tm_next = pwdata[PW-1:0];
        end
    end

    // previous probe kept here too, so change detection can be judged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= 7'h00;
            tm_reg <= '0;
            prv_reg <= '0;
            qt_reg <= 2'd0;
        end else begin
            cfg_reg <= cfg_next;
            tm_reg <= tm_next;
            prv_reg <= probe;
            qt_reg <= qt_next;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    unmapped_err_a: assert property (pready && (paddr[31:8] != 24'h0 ||
        paddr[7:0] > OFS_COUNT || paddr[1:0] != 2'b00) |->
        pslverr && (pwrite || prdata == 32'h0000_0000)) else $error("unmapped access accepted");
    store_data_a: assert property (wr.en && $past(ce) |-> wr.data == $past(probe))
        else $error("stored data is not the probe");
    port_qual_a: assert property (cfg_reg[1:0] == QSQ_MODE_PORT && q_on && wr.en |->
        $past(cfg_reg[CTRL_QSRC_BIT] ? qual_node : qual_pin)) else $error("store with qual low");
    trans_chg_a: assert property (cfg_reg[1:0] == QSQ_MODE_TRANS && q_on && wr.en |->
        $past(|((probe ^ prv_reg) & tm_reg))) else $error("store without change");
    cond_never_a: assert property (cfg_reg[3:0] == 4'hf && q_on |-> !wr.en)
        else $error("store with false condition");
    cont_every_a: assert property ((cfg_reg[1:0] == QSQ_MODE_CONT || cfg_reg[6]) && quiet
        && wr.en && !triggered |=> wr.en || triggered) else $error("continuous store gap");
    addr_step_a: assert property (wr.en && $past(wr.en) && quiet |->
        wr.addr == $past(wr.addr) + 1'b1) else $error("write position skipped");
    disc_mark_a: assert property (cfg_reg[4] && quiet && wr.en && !$past(wr.en) &&
        $past(wr.en, 2) |-> wr.disc) else $error("gap not marked");
endmodule // qsq_top_monitor

bind qsq_top qsq_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .probe(probe), .qual_pin(qual_pin),
    .qual_node(qual_node), .wr(wr), .triggered(triggered));

// [verification/qsq_probe_src.sv]
module qsq_probe_src
    import qsq_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic [1:0]    pat,
    output logic [PW-1:0]      probe,
    output logic               qual_pin,
    output logic               qual_node
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [PW-1:0] cnt_reg, cnt_next;
    logic [1:0]    div_reg, div_next;

    // pat 1 counts each cycle, pat 2 every fourth, pat 0 holds still
    always_comb begin
        div_next = div_reg + 2'd1;
        cnt_next = cnt_reg;
        if (pat == 2'd1 || (pat == 2'd2 && div_reg == 2'd0)) begin
            cnt_next = cnt_reg + PW'(1);
        end
    end

    // all outputs from flops, synchronous to the sample clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            div_reg <= 2'd0;
        end else begin
            cnt_reg <= cnt_next;
            div_reg <= div_next;
        end
    end

    // qual_pin mixes bits and qual_node follows div_reg[1], so runs of both levels occur
    assign probe     = cnt_reg;
    assign qual_pin  = cnt_reg[0] ^ cnt_reg[2] ^ div_reg[1];
    assign qual_node = div_reg[1];
endmodule // qsq_probe_src

// [verification/testbench.sv]
module testbench
    import qsq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic          qual_pin, qual_node, triggered;
    logic [31:0]   paddr, pwdata, prdata, rd, ctrl_v, tmask_v, cond0_v, cond1_v, amask_v;
    logic [PW-1:0] probe;
    logic [1:0]    pat;
    qsq_wr_t       wr;
    int            n_fail, samples_checked, cyc;

    qsq_top dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .probe(probe), .qual_pin(qual_pin), .qual_node(qual_node),
        .wr(wr), .triggered(triggered));
    qsq_probe_src u_src (.pclk(pclk), .presetn(presetn), .pat(pat), .probe(probe),
        .qual_pin(qual_pin), .qual_node(qual_node));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // watchdog: far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one transfer; leading idle edge keeps psel from changing twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // reference qualification for the sample p, with pv the cycle before
    function automatic logic exp_q(input logic [PW-1:0] p, input logic [PW-1:0] pv);
        logic [63:0]   cw;
        logic [3:0]    k;
        logic          a, o, h;
        logic [PW-1:0] m;
        cw = {cond1_v, cond0_v};
        a = 1'b1;
        o = 1'b0;
        m = p & amask_v[PW-1:0];
        for (int i = 0; i < PW; i++) begin
            k = cw[4*i +: 4];
            case (k)
                MT_DC: h = 1'b1;
                MT_LOW: h = !p[i];
                MT_HIGH: h = p[i];
                MT_FALL: h = pv[i] & !p[i];
                MT_RISE: h = !pv[i] & p[i];
                MT_EDGE: h = pv[i] ^ p[i];
                default: h = 1'b0;
            endcase
            a &= h;
            if (k != MT_DC) o |= h;
        end
        if (ctrl_v[6] || ctrl_v[1:0] == 2'd0) return 1'b1;
        if (ctrl_v[1:0] == 2'd1) return ctrl_v[5] ? qual_node : qual_pin;
        if (ctrl_v[1:0] == 2'd2) return |((p ^ pv) & tmask_v[PW-1:0]);
        case (ctrl_v[3:2])
            2'd0: return a;
            2'd1: return o;
            2'd2: case (ctrl_v[14:12])
                3'd0: return m == 16'h0007;
                3'd1: return m != 16'h0007;
                3'd2: return m < 16'h0007;
                3'd3: return m > 16'h0007;
                3'd4: return m <= 16'h0007;
                3'd5: return m >= 16'h0007;
                default: return 1'b0;
            endcase
            default: return 1'b0;
        endcase
    endfunction

    // start with ctrl_v, judge n running cycles one by one, then stop
    task automatic run_chk(input int n);
        logic [PW-1:0] p, pv;
        logic          q, pz;
        int            st;
        st = 0;
        pz = 1'b0;
        apb(1'b1, OFS_CTRL, ctrl_v | 32'h0000_0100);
        @(posedge pclk);
        pv = probe;
        repeat (n) begin
            @(posedge pclk);
            p = probe;
            q = exp_q(p, pv);
            #1;
            chk("store enable", wr.en, q);
            if (q) begin
                chk("store data", wr.data, p);
                chk("store addr", wr.addr, st[7:0]);
                chk("gap mark", wr.disc, ctrl_v[4] & pz);
                st++;
            end
            pz = !q;
            pv = p;
        end
        apb(1'b1, OFS_CTRL, ctrl_v | 32'h0000_0200);
    endtask

    task automatic t_regs();
        chk("idle store", wr.en, 1'b0);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl after reset", rd, RST_WORD);
        apb(1'b1, 8'h28, 32'h0000_00ff);
        chk("unmapped error", er, 1'b1);
        apb(1'b0, 8'h2c, 32'h0);
        chk("unmapped read", rd, RST_WORD);
        apb(1'b1, OFS_STATUS, 32'hffff_ffff);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status read only", rd, RST_WORD);
    endtask

    task automatic t_port();
        ctrl_v = 32'h0000_0011;
        run_chk(24);
        ctrl_v = 32'h0000_0021;
        run_chk(16);
    endtask

    task automatic t_trans();
        tmask_v = 32'h0000_0002;
        apb(1'b1, OFS_TMASK, tmask_v);
        ctrl_v = 32'h0000_0012;
        pat <= 2'd2;
        run_chk(24);
        pat <= 2'd0;
        run_chk(8);
        pat <= 2'd1;
    endtask

    // codes low to either edge plus one unused code on signal 0, then two terms, then a high signal alone
    task automatic t_cond();
        ctrl_v = 32'h0000_0003;
        for (int c = 1; c <= 6; c++) begin
            cond0_v = c;
            apb(1'b1, OFS_COND0, cond0_v);
            run_chk(10);
        end
        cond0_v = 32'h0000_0041;   // low on signal 0 with a rise on signal 1 can both hold
        apb(1'b1, OFS_COND0, cond0_v);
        run_chk(12);
        ctrl_v = 32'h0000_0007;
        run_chk(12);
        cond0_v = 32'h0000_0000;
        cond1_v = 32'h0000_0002;
        apb(1'b1, OFS_COND0, cond0_v);
        apb(1'b1, OFS_COND1, cond1_v);
        run_chk(8);
    endtask

    task automatic t_adv();
        amask_v = 32'h0000_000f;
        apb(1'b1, OFS_ADV_MASK, amask_v);
        apb(1'b1, OFS_ADV_VAL, 32'h0000_0007);
        for (int op = 0; op < 8; op++) begin
            ctrl_v = 32'h0000_000b | (op << CTRL_OP_LSB);
            run_chk(10);
        end
        ctrl_v = 32'h0000_000f;
        run_chk(8);
    endtask

    task automatic t_cont();
        ctrl_v = 32'h0000_0000;
        run_chk(10);
        ctrl_v = 32'h0000_0041;
        run_chk(10);
    endtask

    // trigger must fire although the condition never allows a store
    task automatic t_trig();
        int k;
        int ns;
        ns = 0;
        apb(1'b1, OFS_TRG_MASK, 32'h0000_0003);
        apb(1'b1, OFS_TRG_VAL, 32'h0000_0003);
        ctrl_v = 32'h0000_000f;
        apb(1'b1, OFS_CTRL, ctrl_v | 32'h0000_0100);
        for (k = 0; k < 12 && triggered !== 1'b1; k++) begin
            @(posedge pclk);
            #1;
            if (wr.en !== 1'b0) ns++;
        end
        chk("trigger level", triggered, 1'b1);
        chk("stores while waiting", ns, 0);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status flags", rd[1:0], 2'b10);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pat = 2'd1;
        {ctrl_v, tmask_v, cond0_v, cond1_v, amask_v} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_port();
        t_trans();
        t_cond();
        t_adv();
        t_cont();
        t_trig();
        complete_run();
    end
endmodule // testbench
